// >>> ofca_pkg.sv
// Package: constants, types and records of the ORB fetch and command agent
package ofca_pkg;
  localparam int QUAD_W = 32;
  localparam int ADDR_W = 48;
  localparam logic [11:0] OFS_MGMT_HI = 12'h000;
  localparam logic [11:0] OFS_MGMT_LO = 12'h004;
  localparam logic [11:0] OFS_CMD_BASE = 12'h100;
  localparam logic [11:0] OFS_ORBP_HI = 12'h108;
  localparam logic [11:0] OFS_ORBP_LO = 12'h10C;
  localparam logic [11:0] OFS_BELL = 12'h110;
  localparam logic [3:0] LOGIN_QUADS = 4'h6;
  localparam logic [3:0] ORB_QUADS = 4'h6;
  localparam logic [3:0] LINK_QUADS = 4'h2;
  localparam int LQ_PW_HI = 0;
  localparam int LQ_PW_LO = 1;
  localparam int LQ_RSP_HI = 2;
  localparam int LQ_RSP_LO = 3;
  localparam int LQ_STAT_HI = 4;
  localparam int LQ_STAT_LO = 5;
  localparam int OQ_NEXT_HI = 0;
  localparam int OQ_NEXT_LO = 1;
  localparam int OQ_DATA_HI = 2;
  localparam int OQ_DATA_LO = 3;
  localparam int OQ_OPT = 4;
  localparam int OQ_CDB = 5;
  localparam int NULL_BIT = 31;
  localparam int FIFO_DEPTH = 32;
  localparam logic [47:0] CSR_BASE_DEF = 48'hFFFF_F000_4000;

  typedef enum logic [2:0] {AG_RESET = 3'b001, AG_ACTIVE = 3'b010, AG_SUSP = 3'b100} ofca_agent_e;
  typedef enum logic [1:0] {MG_RESET = 2'b01, MG_LOGGED = 2'b10} ofca_mgmt_e;
  typedef enum logic [5:0] {
    F_IDLE = 6'b000001, F_REQ = 6'b000010, F_DATA = 6'b000100,
    F_LCHK = 6'b001000, F_PUSH = 6'b010000, F_LINK = 6'b100000
  } ofca_fetch_e;
  typedef enum logic [3:0] {W_IDLE = 4'b0001, W_LOGIN = 4'b0010, W_STAT = 4'b0100, W_DATA = 4'b1000} ofca_wr_e;
  typedef enum logic [2:0] {K_LOGIN = 3'b001, K_ORB = 3'b010, K_LINK = 3'b100} ofca_kind_e;

  typedef struct packed {logic valid; logic [11:0] ofs; logic [QUAD_W-1:0] data;} ofca_csr_s;
  typedef struct packed {logic valid; logic [ADDR_W-1:0] addr; logic [3:0] len;} ofca_rd_req_s;
  typedef struct packed {logic valid; logic [QUAD_W-1:0] data;} ofca_rd_beat_s;
  typedef struct packed {
    logic valid; logic first; logic last; logic [ADDR_W-1:0] addr; logic [QUAD_W-1:0] data;
  } ofca_wr_beat_s;
  typedef struct packed {
    logic [ADDR_W-1:0] orb_addr; logic [ADDR_W-1:0] data_addr; logic [QUAD_W-1:0] opt; logic [QUAD_W-1:0] cdb;
  } ofca_orb_s;
  typedef struct packed {logic valid; logic [ADDR_W-1:0] orb_addr; logic [15:0] sense;} ofca_done_s;
endpackage

// >>> ofca_fifo.sv
// Module: flip-flop FIFO holding fetched ORBs
`timescale 1ns/1ps
module ofca_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_srst,
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("ofca_fifo depth must be a power of two of at least 2");
  end

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  wire           push = i_in_valid && o_in_ready;
  wire           pop  = o_out_valid && i_out_ready;

  assign o_in_ready  = (count != DEPTH[AW:0]);
  assign o_out_valid = (count != '0);
  assign o_out_data  = mem[rd_ptr];

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(pop);
      count  <= count + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule

// >>> ofca_agent.sv
// Module: login, ORB fetch, command agent states and memory write engine
`timescale 1ns/1ps
module ofca_agent
  import ofca_pkg::*;
#(
  parameter logic [ADDR_W-1:0] CSR_BASE = CSR_BASE_DEF,
  parameter int                DEPTH    = FIFO_DEPTH
) (
  input  wire logic           i_ref_clk,
  input  wire logic           i_srst,
  input  wire logic           i_bus_reset,
  input  wire ofca_csr_s      i_csr,
  input  wire logic [63:0]    i_cur_password,
  input  wire logic [63:0]    i_master_password,
  output ofca_rd_req_s        o_rd_req,
  input  wire logic           i_rd_gnt,
  input  wire ofca_rd_beat_s  i_rd,
  output logic                o_orb_valid,
  output ofca_orb_s           o_orb,
  input  wire logic           i_orb_ready,
  input  wire ofca_done_s     i_done,
  output logic                o_done_ack,
  input  wire ofca_wr_beat_s  i_xd,
  output logic                o_xd_ack,
  output ofca_wr_beat_s       o_mw,
  input  wire logic           i_mw_ready,
  output ofca_agent_e         o_agent,
  output logic                o_logged_in,
  output logic                o_login_fail
);
  if (DEPTH < 2 || DEPTH > 32) begin : g_chk
    $error("ofca_agent ORB storage depth must lie in 2..32");
  end

  function automatic logic [ADDR_W-1:0] quad_addr(input logic [ADDR_W-1:0] base, input logic [2:0] k);
    return base + {43'b0, k, 2'b00};
  endfunction

  function automatic ofca_wr_beat_s mk_beat(input logic first, input logic last,
                                            input logic [ADDR_W-1:0] addr, input logic [QUAD_W-1:0] data);
    ofca_wr_beat_s b;
    b.valid = 1'b1;
    b.first = first;
    b.last  = last;
    b.addr  = addr;
    b.data  = data;
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State and storage
  ofca_agent_e       agent;
  ofca_mgmt_e        mgmt;
  ofca_fetch_e       fst;
  ofca_wr_e          wst;
  ofca_kind_e        kind;
  logic [QUAD_W-1:0] q [6];
  logic [2:0]        qidx;
  logic [ADDR_W-1:0] cur_addr;
  logic [ADDR_W-1:0] next_addr;
  logic [ADDR_W-1:0] last_orb;
  logic [ADDR_W-1:0] rsp_addr;
  logic [ADDR_W-1:0] stat_addr;
  logic [15:0]       mgmt_hi;
  logic [15:0]       orbp_hi;
  logic              login_pend;
  logic              have_next;
  logic              null_seen;
  logic              relink;
  logic              db_pend;
  logic              rsp_pend;
  logic [5:0]        outstanding;
  logic [2:0]        wk;
  logic              go_link;
  ofca_done_s        stat;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  ofca_orb_s         fifo_out;

  ////////////////////////////////////////////////////////////////////////////////
  // Register decode
  wire clr        = i_srst || i_bus_reset;
  wire csr_ok     = i_csr.valid && (i_csr.ofs[1:0] == 2'b00);
  wire wr_mgmt_hi = csr_ok && (i_csr.ofs == OFS_MGMT_HI);
  wire wr_mgmt_lo = csr_ok && (i_csr.ofs == OFS_MGMT_LO);
  wire wr_orbp_hi = csr_ok && (i_csr.ofs == OFS_ORBP_HI);
  wire wr_orbp_lo = csr_ok && (i_csr.ofs == OFS_ORBP_LO);
  wire wr_bell    = csr_ok && (i_csr.ofs == OFS_BELL);
  wire [ADDR_W-1:0] cmd_base = CSR_BASE + {36'b0, OFS_CMD_BASE};

  ////////////////////////////////////////////////////////////////////////////////
  // Command agent transitions
  wire start    = wr_orbp_lo && (agent == AG_RESET) && (mgmt == MG_LOGGED);
  wire wake     = wr_bell && (agent == AG_SUSP);
  wire drained  = (agent == AG_ACTIVE) && null_seen && (outstanding == '0) && (fst == F_IDLE);
  wire bell_q   = wr_bell && (agent == AG_ACTIVE) && null_seen;
  wire link_nul = (fst == F_LINK) && q[OQ_NEXT_HI][NULL_BIT];
  wire ofca_agent_e next_agent = clr ? AG_RESET :
                                 start ? AG_ACTIVE :
                                 wake ? AG_ACTIVE :
                                 (drained && !db_pend && !bell_q) ? AG_SUSP :
                                 link_nul ? AG_SUSP : agent;

  always_ff @(posedge i_ref_clk) begin
    agent <= next_agent;
    if (clr) begin
      db_pend <= 1'b0;
      relink  <= 1'b0;
    end else begin
      // Bell seen while draining is kept so no relinked work is lost
      db_pend <= drained ? 1'b0 : (db_pend || bell_q);
      relink  <= (wake || (drained && (db_pend || bell_q))) ? 1'b1 : ((fst == F_IDLE && go_link) ? 1'b0 : relink);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Fetch engine
  wire go_login = (fst == F_IDLE) && login_pend;
  assign go_link = (fst == F_IDLE) && !login_pend && (agent == AG_ACTIVE) && relink;
  wire go_orb   = (fst == F_IDLE) && !login_pend && (agent == AG_ACTIVE) && !relink && !null_seen
                  && have_next && fifo_in_ready;
  wire pw_ok    = ({q[LQ_PW_HI], q[LQ_PW_LO]} == i_cur_password)
                  || ({q[LQ_PW_HI], q[LQ_PW_LO]} == i_master_password);
  wire login_ok = (fst == F_LCHK) && pw_ok;
  wire last_q   = i_rd.valid && ({1'b0, qidx} == o_rd_req.len - 4'h1);
  wire push     = (fst == F_PUSH) && fifo_in_ready;
  wire orb_null = q[OQ_NEXT_HI][NULL_BIT];
  wire [ADDR_W-1:0] link_addr = {q[OQ_NEXT_HI][15:0], q[OQ_NEXT_LO]};
  wire ofca_orb_s orb_rec = '{orb_addr: cur_addr, data_addr: {q[OQ_DATA_HI][15:0], q[OQ_DATA_LO]},
                              opt: q[OQ_OPT], cdb: q[OQ_CDB]};

  always_ff @(posedge i_ref_clk) begin
    if (clr) begin
      fst          <= F_IDLE;
      kind         <= K_LOGIN;
      qidx         <= '0;
      o_rd_req     <= '0;
      cur_addr     <= '0;
      login_pend   <= 1'b0;
      mgmt         <= MG_RESET;
      o_login_fail <= 1'b0;
    end else begin
      o_login_fail <= (fst == F_LCHK) && !pw_ok;
      if (wr_mgmt_lo && mgmt == MG_RESET) begin
        login_pend <= 1'b1;
        cur_addr   <= {mgmt_hi, i_csr.data};
      end
      case (fst)
        F_IDLE: begin
          qidx <= '0;
          if (go_login) begin
            login_pend <= 1'b0;
            kind       <= K_LOGIN;
            o_rd_req   <= '{valid: 1'b1, addr: cur_addr, len: LOGIN_QUADS};
            fst        <= F_REQ;
          end else if (go_link) begin
            kind     <= K_LINK;
            o_rd_req <= '{valid: 1'b1, addr: last_orb, len: LINK_QUADS};
            fst      <= F_REQ;
          end else if (go_orb) begin
            kind     <= K_ORB;
            cur_addr <= next_addr;
            o_rd_req <= '{valid: 1'b1, addr: next_addr, len: ORB_QUADS};
            fst      <= F_REQ;
          end
        end
        F_REQ: begin
          if (i_rd_gnt) begin
            o_rd_req.valid <= 1'b0;
            fst            <= F_DATA;
          end
        end
        F_DATA: begin
          if (i_rd.valid) begin
            q[qidx] <= i_rd.data;
            qidx    <= qidx + 3'd1;
          end
          if (last_q) begin
            fst <= (kind == K_LOGIN) ? F_LCHK : ((kind == K_ORB) ? F_PUSH : F_LINK);
          end
        end
        F_LCHK: begin
          if (pw_ok) begin
            mgmt <= MG_LOGGED;
          end
          fst <= F_IDLE;
        end
        F_PUSH: begin
          if (push) begin
            fst <= F_IDLE;
          end
        end
        F_LINK: fst <= F_IDLE;
        default: fst <= F_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (clr) begin
      mgmt_hi   <= '0;
      orbp_hi   <= '0;
      next_addr <= '0;
      last_orb  <= '0;
      rsp_addr  <= '0;
      stat_addr <= '0;
      have_next <= 1'b0;
      null_seen <= 1'b0;
    end else begin
      if (wr_mgmt_hi) mgmt_hi <= i_csr.data[15:0];
      if (wr_orbp_hi) orbp_hi <= i_csr.data[15:0];
      if (login_ok) begin
        rsp_addr  <= {q[LQ_RSP_HI][15:0], q[LQ_RSP_LO]};
        stat_addr <= {q[LQ_STAT_HI][15:0], q[LQ_STAT_LO]};
      end
      if (start) begin
        next_addr <= {orbp_hi, i_csr.data};
        have_next <= 1'b1;
        null_seen <= 1'b0;
      end else if (push) begin
        last_orb  <= cur_addr;
        null_seen <= orb_null;
        next_addr <= link_addr;
      end else if (fst == F_LINK && !orb_null) begin
        next_addr <= link_addr;
      end
      if (wake || drained) null_seen <= 1'b0;
    end
  end

  ofca_fifo #(
    .W     ($bits(ofca_orb_s)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_srst      (clr),
    .i_in_valid  (fst == F_PUSH),
    .i_in_data   (orb_rec),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out),
    .i_out_ready (!o_orb_valid || i_orb_ready)
  );

  // Output slice towards the execution engine, which may run ORBs out of order
  always_ff @(posedge i_ref_clk) begin
    if (clr) begin
      o_orb_valid <= 1'b0;
      o_orb       <= '0;
    end else if (!o_orb_valid || i_orb_ready) begin
      o_orb_valid <= fifo_out_valid;
      o_orb       <= fifo_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Memory write engine: login response, read data, status blocks
  wire free     = !o_mw.valid || i_mw_ready;
  wire take_xd  = (wst == W_DATA) && free && i_xd.valid && !o_xd_ack;
  wire stat_end = (wst == W_STAT) && free && (wk == 3'd1);
  wire [QUAD_W-1:0] stat_q = (wk == 3'd0) ? {stat.sense, stat.orb_addr[47:32]} : stat.orb_addr[31:0];
  wire [QUAD_W-1:0] rsp_q  = (wk == 3'd0) ? {16'h0000, cmd_base[47:32]} : cmd_base[31:0];

  always_ff @(posedge i_ref_clk) begin
    if (clr) begin
      wst        <= W_IDLE;
      wk         <= '0;
      o_mw       <= '0;
      stat       <= '0;
      rsp_pend   <= 1'b0;
      o_done_ack <= 1'b0;
      o_xd_ack   <= 1'b0;
    end else begin
      o_done_ack <= 1'b0;
      o_xd_ack   <= take_xd;
      if (login_ok) rsp_pend <= 1'b1;
      if (free) o_mw.valid <= 1'b0;
      case (wst)
        W_IDLE: begin
          wk <= '0;
          if (rsp_pend || login_ok) begin
            rsp_pend <= 1'b0;
            wst      <= W_LOGIN;
          end else if (i_xd.valid && !o_xd_ack) begin
            wst <= W_DATA;
          end else if (i_done.valid && !o_done_ack) begin
            stat       <= i_done;
            o_done_ack <= 1'b1;
            wst        <= W_STAT;
          end
        end
        W_LOGIN: begin
          if (free) begin
            o_mw <= mk_beat(wk == 3'd0, wk == 3'd1, quad_addr(rsp_addr, wk), rsp_q);
            wk   <= wk + 3'd1;
            if (wk == 3'd1) wst <= W_IDLE;
          end
        end
        W_STAT: begin
          if (free) begin
            o_mw <= mk_beat(wk == 3'd0, wk == 3'd1, quad_addr(stat_addr, wk), stat_q);
            wk   <= wk + 3'd1;
            if (wk == 3'd1) wst <= W_IDLE;
          end
        end
        W_DATA: begin
          if (take_xd) begin
            o_mw <= mk_beat(i_xd.first, i_xd.last, i_xd.addr, i_xd.data);
            if (i_xd.last) wst <= W_IDLE;
          end
        end
        default: wst <= W_IDLE;
      endcase
    end
  end

  // ORBs fetched and not yet closed by a status block
  always_ff @(posedge i_ref_clk) begin
    if (clr) outstanding <= '0;
    else outstanding <= outstanding + 6'(push) - 6'(stat_end);
  end

  assign o_agent     = agent;
  // Logged-in bit of the one-hot management state
  assign o_logged_in = mgmt[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  sequence s_fetch_issued;
    ##[1:3] o_rd_req.valid && (o_rd_req.len == ORB_QUADS);
  endsequence
  sequence s_link_issued;
    ##[1:3] o_rd_req.valid && (o_rd_req.addr == last_orb) && (o_rd_req.len == LINK_QUADS);
  endsequence

  a_bus_reset_agents: assert property (i_bus_reset |=> agent == AG_RESET && mgmt == MG_RESET)
    else $error("agents not in Reset after bus reset");
  a_bad_password: assert property ((fst == F_LCHK && !pw_ok && mgmt == MG_RESET && !i_bus_reset)
    |=> mgmt == MG_RESET && o_login_fail)
    else $error("login accepted without valid password");
  a_login_resp: assert property ((wst == W_LOGIN && free && wk == 3'd0) |=> o_mw.addr == rsp_addr && o_mw.first)
    else $error("login response to wrong address");
  a_orbp_start: assert property ((start && fst == F_IDLE && !login_pend && fifo_in_ready && !i_bus_reset)
    |=> agent == AG_ACTIVE ##0 s_fetch_issued)
    else $error("ORB pointer write did not start fetching");
  a_bell_in_reset: assert property ((wr_bell && agent == AG_RESET && !start && !i_bus_reset) |=> agent == AG_RESET)
    else $error("doorbell acted in Reset");
  a_stop_at_null: assert property ((fst == F_IDLE && null_seen)
    |=> !(o_rd_req.valid && o_rd_req.len == ORB_QUADS))
    else $error("fetch continued past NULL ORB");
  a_status_addr: assert property ((wst == W_STAT && free && !i_bus_reset)
    |=> o_mw.valid && o_mw.addr == quad_addr(stat_addr, $past(wk)))
    else $error("status block at wrong address");
  a_suspend_drain: assert property ($rose(agent == AG_SUSP) && !$past(link_nul) |-> $past(outstanding) == 6'd0)
    else $error("suspended with commands outstanding");
  a_bell_wake: assert property ((wake && !i_bus_reset) |=> agent == AG_ACTIVE && relink)
    else $error("doorbell did not wake agent");
  a_bell_relink: assert property ((go_link && !i_bus_reset) |-> s_link_issued)
    else $error("relink read not issued at last ORB");
  a_bell_active: assert property ((wr_bell && agent == AG_ACTIVE && !null_seen && !link_nul && !i_bus_reset)
    |=> agent == AG_ACTIVE && $stable(db_pend))
    else $error("doorbell acted while fetching");
endmodule

// >>> ofca_initiator.sv
// Initiator node model: system memory served by reads, filled by block writes
`timescale 1ns/1ps
module ofca_initiator
  import ofca_pkg::*;
(
  input  wire logic          i_ref_clk,
  input  wire logic          i_srst,
  input  wire ofca_rd_req_s  i_rd_req,
  output logic               o_rd_gnt,
  output ofca_rd_beat_s      o_rd,
  input  wire ofca_wr_beat_s i_mw,
  output logic               o_mw_ready
);
  logic [QUAD_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] ra;
  int                left    = 0;
  int                n_reads = 0;
  logic              slow    = 1'b0;

  initial begin
    o_rd_gnt   = 1'b0;
    o_rd       = '0;
    o_mw_ready = 1'b1;
  end

  always @(posedge i_ref_clk) begin
    o_rd_gnt   <= 1'b0;
    o_rd       <= {1'b0, ~o_rd.data};
    o_mw_ready <= slow ? ~o_mw_ready : 1'b1;
    if (i_srst) begin
      left = 0;
    end else if (left > 0) begin
      // One quadlet per beat, in address order
      o_rd <= {1'b1, mem.exists(ra) ? mem[ra] : ~ra[31:0]};
      ra = ra + 48'h4;
      left--;
    end else if (i_rd_req.valid === 1'b1 && !o_rd_gnt) begin
      o_rd_gnt <= 1'b1;
      ra = i_rd_req.addr;
      left = int'(i_rd_req.len);
      n_reads++;
    end
    if (i_mw.valid === 1'b1 && o_mw_ready) begin
      mem[i_mw.addr] = i_mw.data;
    end
  end
endmodule

// >>> orb_fetch_command_agent_tb.sv
// Testbench: login, ORB list fetch, data, status, relink and bus reset
`timescale 1ns/1ps
module orb_fetch_command_agent_tb;
  import ofca_pkg::*;
  localparam logic [47:0] BASE = CSR_BASE_DEF + 48'h100;
  localparam logic [47:0] LGN = 48'h1000, RSP = 48'h1100, STA = 48'h1200, ORB0 = 48'h2000, DAT = 48'h8000;
  localparam logic [47:0] NEWO = 48'h3000;
  localparam int NN = 40;
  localparam logic [63:0] CUR = 64'h1111_2222_3333_4444, MST = 64'h5555_6666_7777_8888;
  logic clk = 1'b0, srst = 1'b1, bus_rst = 1'b0, orb_ready = 1'b0;
  ofca_csr_s csr = '0;
  ofca_done_s done = '0;
  ofca_wr_beat_s xd = '0, mw;
  ofca_rd_req_s rd_req;
  ofca_rd_beat_s rd;
  ofca_orb_s orb;
  ofca_agent_e agent;
  logic rd_gnt, orb_valid, done_ack, xd_ack, mw_ready, logged, lfail;
  int fails = 0, n_compared = 0, cyc = 0;

  ofca_agent uut (
    .i_ref_clk(clk), .i_srst(srst), .i_bus_reset(bus_rst), .i_csr(csr),
    .i_cur_password(CUR), .i_master_password(MST), .o_rd_req(rd_req), .i_rd_gnt(rd_gnt),
    .i_rd(rd), .o_orb_valid(orb_valid), .o_orb(orb), .i_orb_ready(orb_ready), .i_done(done),
    .o_done_ack(done_ack), .i_xd(xd), .o_xd_ack(xd_ack), .o_mw(mw), .i_mw_ready(mw_ready),
    .o_agent(agent), .o_logged_in(logged), .o_login_fail(lfail)
  );
  ofca_initiator ini (
    .i_ref_clk(clk), .i_srst(srst), .i_rd_req(rd_req), .o_rd_gnt(rd_gnt), .o_rd(rd),
    .i_mw(mw), .o_mw_ready(mw_ready)
  );

  always #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (fails == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      complete_run;
    end
  end

  task automatic check(input string nm, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask

  task automatic put6(input logic [47:0] a, input logic [31:0] q [6]);
    for (int j = 0; j < 6; j++) ini.mem[a + 48'(4 * j)] = q[j];
  endtask

  task automatic csr_wr(input logic [11:0] o, input logic [31:0] d);
    csr <= {1'b1, o, d};
    @(posedge clk);
    csr <= '0;
    @(posedge clk);
  endtask

  task automatic wait_mem(input string nm, input logic [47:0] a, input logic [31:0] exp);
    for (int k = 0; k < 300 && !(ini.mem.exists(a) && ini.mem[a] === exp); k++) @(posedge clk);
    check(nm, exp, ini.mem.exists(a) ? ini.mem[a] : ~exp);
  endtask

  task automatic wait_agent(input ofca_agent_e e);
    for (int k = 0; k < 300 && agent !== e; k++) @(posedge clk);
    check("agent", e, agent);
  endtask

  task automatic login(input logic [63:0] pw, input logic ok);
    logic seen_fail;
    seen_fail = 1'b0;
    put6(LGN, '{pw[63:32], pw[31:0], 32'h0, RSP[31:0], 32'h0, STA[31:0]});
    csr_wr(OFS_MGMT_HI, 32'h0);
    csr_wr(OFS_MGMT_LO, LGN[31:0]);
    for (int k = 0; k < 200 && logged !== 1'b1 && !seen_fail; k++) begin
      @(posedge clk);
      seen_fail = (lfail === 1'b1);
    end
    check("logged_in", ok, logged);
    check("login_fail", !ok, seen_fail);
  endtask

  task automatic take_orb(input logic [47:0] a, input logic [31:0] c);
    for (int k = 0; k < 300 && orb_valid !== 1'b1; k++) @(posedge clk);
    check("orb_addr", a, orb.orb_addr);
    check("orb_data", DAT, orb.data_addr);
    check("orb_cdb", c, orb.cdb);
    orb_ready <= 1'b1;
    @(posedge clk);
    orb_ready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic finish(input logic [47:0] a, input logic [15:0] s);
    done <= {1'b1, a, s};
    @(posedge clk);
    for (int k = 0; k < 300 && done_ack !== 1'b1; k++) @(posedge clk);
    done <= '0;
    @(posedge clk);
    wait_mem("stat_lo", STA + 48'h4, a[31:0]);
    check("stat_hi", {s, a[47:32]}, ini.mem[STA]);
  endtask

  task automatic send_data(input logic [47:0] a, input logic [31:0] d, input logic f, input logic l);
    xd <= {1'b1, f, l, a, d};
    @(posedge clk);
    for (int k = 0; k < 300 && xd_ack !== 1'b1; k++) @(posedge clk);
    xd <= '0;
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [47:0] a;
    int rd0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    check("agent", AG_RESET, agent);
    check("logged_in", 1'b0, logged);
    csr_wr(OFS_BELL, 32'h0);
    csr_wr(OFS_ORBP_LO, ORB0[31:0]);
    check("agent", AG_RESET, agent);
    login(~MST, 1'b0);
    login(MST, 1'b1);
    wait_mem("rsp_lo", RSP + 48'h4, BASE[31:0]);
    check("rsp_hi", {16'h0, BASE[47:32]}, ini.mem[RSP]);
    // Chained list, only the last one NULL
    for (int i = 0; i < NN; i++) begin
      a = ORB0 + 48'(32 * i);
      put6(a, '{(i == NN - 1) ? 32'h8000_0000 : 32'h0, a[31:0] + 32'h20, 32'h0, DAT[31:0], 32'h0, 32'(i)});
    end
    rd0 = ini.n_reads;
    ini.slow = 1'b1;
    csr_wr(OFS_ORBP_HI, 32'h0);
    csr_wr(OFS_ORBP_LO, ORB0[31:0]);
    check("agent", AG_ACTIVE, agent);
    csr_wr(OFS_BELL, 32'h0);
    repeat (2000) @(posedge clk);
    check("fetch_stop", 1'b1, (ini.n_reads - rd0) < NN);
    for (int i = 0; i < NN; i++) take_orb(ORB0 + 48'(32 * i), 32'(i));
    send_data(DAT, 32'hA5A5_0001, 1'b1, 1'b0);
    send_data(DAT + 48'h4, 32'hA5A5_0002, 1'b0, 1'b1);
    wait_mem("data1", DAT + 48'h4, 32'hA5A5_0002);
    check("data0", 32'hA5A5_0001, ini.mem[DAT]);
    // Completed out of list order
    for (int i = NN - 1; i >= 0; i--) begin
      check("agent", AG_ACTIVE, agent);
      finish(ORB0 + 48'(32 * i), 16'(i + 1));
    end
    wait_agent(AG_SUSP);
    check("reads", NN, ini.n_reads - rd0);
    a = ORB0 + 48'(32 * (NN - 1));
    put6(NEWO, '{32'h8000_0000, 32'h0, 32'h0, DAT[31:0], 32'h0, 32'h7});
    put6(a, '{32'h0, NEWO[31:0], 32'h0, DAT[31:0], 32'h0, 32'h27});
    csr_wr(OFS_BELL, 32'h0);
    wait_agent(AG_ACTIVE);
    take_orb(NEWO, 32'h7);
    finish(NEWO, 16'h0077);
    wait_agent(AG_SUSP);
    bus_rst <= 1'b1;
    @(posedge clk);
    bus_rst <= 1'b0;
    @(posedge clk);
    check("agent", AG_RESET, agent);
    check("logged_in", 1'b0, logged);
    login(CUR, 1'b1);
    complete_run;
  end
endmodule
